// >>> core/lfp_pkg.sv
// shared constants and types of the lookup-table fan pwm controller
package lfp_pkg;

	localparam int OFS_STEPS  = 12;
	localparam int LEVELS     = 13;
	localparam int ZONES      = 4;
	localparam int OUTS       = 2;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_BIND    = 8'h04;
	localparam logic [7:0] OFS_BASE    = 8'h08;
	localparam logic [7:0] OFS_HYST    = 8'h0c;
	localparam logic [7:0] OFS_MIN     = 8'h10;
	localparam logic [7:0] OFS_TBL12_L = 8'h14;
	localparam logic [7:0] OFS_TBL12_H = 8'h18;
	localparam logic [7:0] OFS_TBL34_L = 8'h1c;
	localparam logic [7:0] OFS_TBL34_H = 8'h20;
	localparam logic [7:0] OFS_TEMP    = 8'h24;
	localparam logic [7:0] OFS_STAT    = 8'h28;
	localparam logic [7:0] OFS_DIV     = 8'h2c;

	// control fields
	localparam int CTRL_EN_BIT      = 0;
	localparam int CTRL_HALF_BIT    = 1;
	localparam int CTRL_HIFREQ_BIT  = 2;
	localparam int CTRL_W           = 4;

	// status fields
	localparam int STAT_IDLE_POS    = 16;
	localparam int STAT_DUTY_POS    = 20;

	// reset values
	localparam logic [3:0]  CTRL_RST = 4'h3;
	localparam logic [7:0]  BIND_RST = 8'hc3;
	localparam logic [31:0] BASE_RST = 32'h00000000;
	localparam logic [7:0]  HYST_RST = 8'h44;
	localparam logic [7:0]  MIN_RST  = 8'h44;
	localparam logic [15:0] DIV_RST  = 16'h0046;

	// timing: slot prescaler floor keeps the pwm at or below its top rate
	localparam int CLK_HZ      = 25000000;
	localparam int PWM_MAX_HZ  = 22500;
	localparam int SLOTS_HI    = 16;
	localparam int DIV_MIN_INT = (CLK_HZ + PWM_MAX_HZ * SLOTS_HI - 1)
		/ (PWM_MAX_HZ * SLOTS_HI);
	localparam logic [15:0] DIV_MIN = 16'(DIV_MIN_INT);

	// duty denominators and fixed step duties (index 0 = lowest step)
	localparam logic [4:0] DEN_HI = 5'h10;
	localparam logic [4:0] DEN_LO = 5'h1c;
	localparam logic [12:0][4:0] DUTY_HI = {5'h10, 5'h0f, 5'h0e, 5'h0d,
		5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
	localparam logic [12:0][4:0] DUTY_LO = {5'h1c, 5'h18, 5'h14, 5'h10,
		5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07};

	typedef struct packed {
		logic [7:0] base;
		logic [3:0] hyst;
		logic       res_half;
	} lfp_zone_cfg_t;

	typedef struct packed {
		logic [4:0] num;
		logic [4:0] den;
	} lfp_duty_t;

endpackage : lfp_pkg

// >>> core/lfp_zone_step.sv
// one zone: cumulative thresholds, step selection and hysteresis
`timescale 1ns/1ps
module lfp_zone_step (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire lfp_pkg::lfp_zone_cfg_t cfg,
	input  wire logic [11:0][3:0]      offsets,
	input  wire logic [8:0]            temp,
	output logic      [3:0]            level_q,
	output logic                       idle_q
);
	logic [10:0] base_h;
	logic [10:0] temp_h;
	logic [10:0] hyst_h;
	logic [10:0] acc;
	logic [3:0]  cand;
	logic [3:0]  cand_h;
	logic [3:0]  level_d;
	logic        idle_d;

	assign base_h = {2'b00, cfg.base, 1'b0};
	assign temp_h = {2'b00, temp};
	// half-degree grid throughout; whole-degree mode doubles each offset
	assign hyst_h = cfg.res_half ? {7'h00, cfg.hyst}
		: {6'h00, cfg.hyst, 1'b0};

	always_comb begin
		acc    = base_h;
		cand   = 4'h0;
		cand_h = 4'h0;
		for (int k = 0; k < lfp_pkg::OFS_STEPS; k++) begin
			// running sum of offsets on top of the base
			acc = acc + (cfg.res_half ? {7'h00, offsets[k]}
				: {6'h00, offsets[k], 1'b0});
			// zero offset gives an empty band, so that step is skipped
			if (temp_h >= acc) begin
				cand = 4'(k + 1);
			end
			if (temp_h + hyst_h >= acc) begin
				cand_h = 4'(k + 1);
			end
		end
	end

	assign idle_d = (temp_h <= base_h);
	// rise at once, fall only once clear of the band by the hysteresis
	assign level_d = (cand > level_q) ? cand
		: (cand_h < level_q) ? cand_h : level_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= 4'h0;
			idle_q  <= 1'b1;
		end else if (ce) begin
			level_q <= level_d;
			idle_q  <= idle_d;
		end
	end

endmodule : lfp_zone_step

// >>> core/lfp_pwm.sv
// slot-based pwm generator with per-period duty capture
`timescale 1ns/1ps
module lfp_pwm (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic [15:0]        div,
	input  wire lfp_pkg::lfp_duty_t duty,
	output logic                    pwm_q
);
	logic [15:0]        pre_q;
	logic [4:0]         slot_q;
	lfp_pkg::lfp_duty_t cur_q;
	logic               pre_end;
	logic               per_end;

	assign pre_end = (pre_q >= div - 16'h0001);
	assign per_end = pre_end && (slot_q >= cur_q.den - 5'h01);

	// duty is captured only at a period boundary so no runt pulses appear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_q  <= 16'h0000;
			slot_q <= 5'h00;
			cur_q  <= '0;
			pwm_q  <= 1'b0;
		end else if (ce) begin
			pre_q <= pre_end ? 16'h0000 : pre_q + 16'h0001;
			if (per_end) begin
				slot_q <= 5'h00;
				cur_q  <= duty;
			end else if (pre_end) begin
				slot_q <= slot_q + 5'h01;
			end
			pwm_q <= (slot_q < cur_q.num);
		end
	end

endmodule : lfp_pwm

// >>> core/lfp_fan_ctrl.sv
// What this block does
// - fan outputs run up to 22.5 kHz; duty steps are 6.25 percent in the high range only
// - table holds twelve offsets plus a base temperature
// - step duties are fixed, one of two sets per output
// - zones 1/2 share one offset set, zones 3/4 another
// - each zone has its own base temperature
// - hysteresis stops toggling; one value per zone pair
// - threshold is base plus running sum of 4-bit offsets
// - at or below base the output uses the minimum duty setting
// - a zero offset step is skipped
// - low range duties rise non-linearly, high range linearly
// - zones 1/2 from remote diodes, zone 3 from die sensor
// - offsets and hysteresis selectable in 0.5 or 1 degree units
`timescale 1ns/1ps
module lfp_fan_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLOCK,
	input  wire logic              RST_N,
	input  wire logic              CE,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	input  wire logic [3:0]        PSTRB,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic [8:0]        TEMP_REMOTE_ONE,
	input  wire logic [8:0]        TEMP_REMOTE_TWO,
	input  wire logic [8:0]        TEMP_DIE,
	input  wire logic [8:0]        TEMP_ZONE_FOUR,
	output logic                   FAN_DRIVE_OUTPUT_ONE,
	output logic                   FAN_DRIVE_OUTPUT_TWO
);
	localparam int Z = lfp_pkg::ZONES;
	localparam int O = lfp_pkg::OUTS;

	logic [lfp_pkg::CTRL_W-1:0] ctrl_q;
	logic [7:0]                 bind_q;
	logic [31:0]                base_q;
	logic [7:0]                 hyst_q;
	logic [7:0]                 min_q;
	logic [1:0][11:0][3:0]      ofs_q;
	logic [15:0]                div_q;
	logic [31:0]                prdata_q;
	logic                       pready_q;
	logic                       pslverr_q;

	logic [Z-1:0][8:0]          temp_w;
	logic [Z-1:0][3:0]          level_w;
	logic [Z-1:0]               idle_w;
	lfp_pkg::lfp_duty_t [O-1:0] duty_w;
	logic [O-1:0]               pwm_w;
	logic [15:0]                div_eff;

	logic                       setup_acc;
	logic                       commit;
	logic                       wr_commit;
	logic [7:0]                 addr8;
	logic                       hit_ctrl;
	logic                       hit_bind;
	logic                       hit_base;
	logic                       hit_hyst;
	logic                       hit_min;
	logic                       hit_t12l;
	logic                       hit_t12h;
	logic                       hit_t34l;
	logic                       hit_t34h;
	logic                       hit_temp;
	logic                       hit_stat;
	logic                       hit_div;
	logic                       hit_any;
	logic                       hit_ro;
	logic [31:0]                rd_mux;
	logic [31:0]                stat_w;
	logic                       bad_req;
	logic [31:0]                rd_word;

	// merges the enabled byte lanes of a write into the old value
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// zone sources
	assign temp_w[0] = TEMP_REMOTE_ONE;
	assign temp_w[1] = TEMP_REMOTE_TWO;
	assign temp_w[2] = TEMP_DIE;
	assign temp_w[3] = TEMP_ZONE_FOUR;

	// bus decode
	// only a full match of the low 8 address bits decodes; PADDR bits above those are ignored, so aliases decode
	assign addr8     = 8'(PADDR);
	assign setup_acc = PSEL && PENABLE && !pready_q;
	assign commit    = PSEL && PENABLE && pready_q;
	assign hit_ctrl  = (addr8 == lfp_pkg::OFS_CTRL);
	assign hit_bind  = (addr8 == lfp_pkg::OFS_BIND);
	assign hit_base  = (addr8 == lfp_pkg::OFS_BASE);
	assign hit_hyst  = (addr8 == lfp_pkg::OFS_HYST);
	assign hit_min   = (addr8 == lfp_pkg::OFS_MIN);
	assign hit_t12l  = (addr8 == lfp_pkg::OFS_TBL12_L);
	assign hit_t12h  = (addr8 == lfp_pkg::OFS_TBL12_H);
	assign hit_t34l  = (addr8 == lfp_pkg::OFS_TBL34_L);
	assign hit_t34h  = (addr8 == lfp_pkg::OFS_TBL34_H);
	assign hit_temp  = (addr8 == lfp_pkg::OFS_TEMP);
	assign hit_stat  = (addr8 == lfp_pkg::OFS_STAT);
	assign hit_div   = (addr8 == lfp_pkg::OFS_DIV);
	assign hit_ro    = hit_temp || hit_stat;
	assign hit_any   = hit_ctrl || hit_bind || hit_base || hit_hyst
		|| hit_min || hit_t12l || hit_t12h || hit_t34l || hit_t34h
		|| hit_ro || hit_div;
	// a write to a read-only or unmapped word changes nothing
	assign wr_commit = commit && PWRITE && hit_any && !hit_ro;
	// refusals: unmapped words, and writes to the read-only words
	assign bad_req   = !hit_any || (PWRITE && hit_ro);
	// a write answer carries zero so no stale read data rides along
	assign rd_word   = PWRITE ? 32'h00000000 : rd_mux;

	assign stat_w = {2'b00,
		duty_w[1].num, duty_w[0].num,
		idle_w,
		level_w[3], level_w[2], level_w[1], level_w[0]};

	assign rd_mux =
		hit_ctrl ? {28'h0000000, ctrl_q} :
		hit_bind ? {24'h000000, bind_q} :
		hit_base ? base_q :
		hit_hyst ? {24'h000000, hyst_q} :
		hit_min  ? {24'h000000, min_q} :
		hit_t12l ? 32'(ofs_q[0][7:0]) :
		hit_t12h ? {16'h0000, 16'(ofs_q[0][11:8])} :
		hit_t34l ? 32'(ofs_q[1][7:0]) :
		hit_t34h ? {16'h0000, 16'(ofs_q[1][11:8])} :
		hit_temp ? {temp_w[3][8:1], temp_w[2][8:1],
			temp_w[1][8:1], temp_w[0][8:1]} :
		hit_stat ? stat_w :
		hit_div  ? {16'h0000, div_q} : 32'h00000000;

	// APB answer: one wait state, data and error captured with ready
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (CE) begin
			pready_q  <= setup_acc;
			if (setup_acc) begin
				prdata_q  <= rd_word;
				pslverr_q <= bad_req;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// configuration registers
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ctrl_q <= lfp_pkg::CTRL_RST;
			bind_q <= lfp_pkg::BIND_RST;
			base_q <= lfp_pkg::BASE_RST;
			hyst_q <= lfp_pkg::HYST_RST;
			min_q  <= lfp_pkg::MIN_RST;
			ofs_q  <= '0;
			div_q  <= lfp_pkg::DIV_RST;
		end else if (CE && wr_commit) begin
			if (hit_ctrl) begin
				ctrl_q <= lfp_pkg::CTRL_W'(lane_merge(32'(ctrl_q),
					PWDATA, PSTRB));
			end
			if (hit_bind) begin
				bind_q <= 8'(lane_merge(32'(bind_q), PWDATA, PSTRB));
			end
			if (hit_base) begin
				base_q <= lane_merge(base_q, PWDATA, PSTRB);
			end
			if (hit_hyst) begin
				hyst_q <= 8'(lane_merge(32'(hyst_q), PWDATA, PSTRB));
			end
			if (hit_min) begin
				min_q <= 8'(lane_merge(32'(min_q), PWDATA, PSTRB));
			end
			if (hit_t12l) begin
				ofs_q[0][7:0] <= lane_merge(32'(ofs_q[0][7:0]),
					PWDATA, PSTRB);
			end
			if (hit_t12h) begin
				ofs_q[0][11:8] <= 16'(lane_merge(32'(ofs_q[0][11:8]),
					PWDATA, PSTRB));
			end
			if (hit_t34l) begin
				ofs_q[1][7:0] <= lane_merge(32'(ofs_q[1][7:0]),
					PWDATA, PSTRB);
			end
			if (hit_t34h) begin
				ofs_q[1][11:8] <= 16'(lane_merge(32'(ofs_q[1][11:8]),
					PWDATA, PSTRB));
			end
			if (hit_div) begin
				div_q <= 16'(lane_merge(32'(div_q), PWDATA, PSTRB));
			end
		end
	end

	// per zone stepping; pair index picks the shared offsets and hysteresis
	for (genvar z = 0; z < Z; z++) begin : g_zone
		lfp_pkg::lfp_zone_cfg_t cfg_w;
		assign cfg_w.base     = base_q[z*8 +: 8];
		assign cfg_w.hyst     = hyst_q[(z/2)*4 +: 4];
		assign cfg_w.res_half = ctrl_q[lfp_pkg::CTRL_HALF_BIT];
		lfp_zone_step u_step (
			.clk     (CLOCK),
			.rst_n   (RST_N),
			.ce      (CE),
			.cfg     (cfg_w),
			.offsets (ofs_q[z/2]),
			.temp    (temp_w[z]),
			.level_q (level_w[z]),
			.idle_q  (idle_w[z])
		);
	end

	// the prescaler floor caps the rate so software cannot exceed it
	assign div_eff = (div_q < lfp_pkg::DIV_MIN) ? lfp_pkg::DIV_MIN
		: div_q;

	// output duty: the bound zone asking the highest duty wins
	// equal numerators give equal duty, so ties need no arbitration
	for (genvar o = 0; o < O; o++) begin : g_out
		logic       hifreq;
		logic [4:0] best;
		assign hifreq = ctrl_q[lfp_pkg::CTRL_HIFREQ_BIT + o];

		always_comb begin
			logic [3:0] mn;
			logic [6:0] mn7;
			logic [4:0] n;
			mn   = 4'h0;
			mn7  = 7'h00;
			n    = 5'h00;
			best = 5'h00;
			for (int z = 0; z < Z; z++) begin
				mn  = min_q[(z/2)*4 +: 4];
				mn7 = 7'(mn) * 7'h07;
				if (idle_w[z]) begin
					// minimum is kept in sixteenths; rescale for low range
					n = hifreq ? {1'b0, mn} : mn7[6:2];
				end else begin
					n = hifreq ? lfp_pkg::DUTY_HI[level_w[z]]
						: lfp_pkg::DUTY_LO[level_w[z]];
				end
				if (bind_q[o*4 + z] && n > best) begin
					best = n;
				end
			end
		end

		// disabled controller runs fans flat out as the safe state
		assign duty_w[o].den = hifreq ? lfp_pkg::DEN_HI : lfp_pkg::DEN_LO;
		assign duty_w[o].num = ctrl_q[lfp_pkg::CTRL_EN_BIT] ? best
			: duty_w[o].den;

		lfp_pwm u_pwm (
			.clk   (CLOCK),
			.rst_n (RST_N),
			.ce    (CE),
			.div   (div_eff),
			.duty  (duty_w[o]),
			.pwm_q (pwm_w[o])
		);
	end

	// all outputs straight from flip-flops
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			FAN_DRIVE_OUTPUT_ONE <= 1'b0;
			FAN_DRIVE_OUTPUT_TWO <= 1'b0;
		end else if (CE) begin
			FAN_DRIVE_OUTPUT_ONE <= pwm_w[0];
			FAN_DRIVE_OUTPUT_TWO <= pwm_w[1];
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = pready_q;
	assign PSLVERR = pslverr_q;

endmodule : lfp_fan_ctrl

// >>> verif/lfp_fan_ctrl_properties.sv
// bus handshake and pwm slot timing assertions for the fan controller
`timescale 1ns/1ps
module lfp_fan_ctrl_properties #(
	parameter int ADDR_W = 8
) (
	input wire logic              CLOCK,
	input wire logic              RST_N,
	input wire logic              CE,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0]       PWDATA,
	input wire logic [3:0]        PSTRB,
	input wire logic [31:0]       PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	input wire logic [8:0]        TEMP_REMOTE_ONE,
	input wire logic [8:0]        TEMP_REMOTE_TWO,
	input wire logic [8:0]        TEMP_DIE,
	input wire logic [8:0]        TEMP_ZONE_FOUR,
	input wire logic              FAN_DRIVE_OUTPUT_ONE,
	input wire logic              FAN_DRIVE_OUTPUT_TWO
);
	logic [7:0] gap1_q;
	logic [7:0] gap2_q;
	logic       prev1_q;
	logic       prev2_q;
	wire        mapped = (PADDR[1:0] == 2'h0) && (int'(PADDR) <= 44);
	wire        ro_reg = (int'(PADDR) == 36) || (int'(PADDR) == 40);
	wire        chg1 = FAN_DRIVE_OUTPUT_ONE != prev1_q;
	wire        chg2 = FAN_DRIVE_OUTPUT_TWO != prev2_q;
	// saturating count of cycles since each output last changed
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			gap1_q  <= 8'hff;
			gap2_q  <= 8'hff;
			prev1_q <= 1'b0;
			prev2_q <= 1'b0;
		end else if (CE) begin
			prev1_q <= FAN_DRIVE_OUTPUT_ONE;
			prev2_q <= FAN_DRIVE_OUTPUT_TWO;
			gap1_q  <= chg1 ? 8'h00 : gap1_q + 8'(gap1_q != 8'hff);
			gap2_q  <= chg2 ? 8'h00 : gap2_q + 8'(gap2_q != 8'hff);
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	// a frozen clock enable stalls everything, so checks pause with it
	default disable iff (!RST_N || !CE);
	sequence access_s;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence done_s;
		PSEL && PENABLE && PREADY;
	endsequence
	ready_wait_a: assert property (access_s |=> done_s)
		else $error("ready not given one cycle into access");
	ready_pulse_a: assert property (done_s |=> !PREADY)
		else $error("ready held past one cycle");
	ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside an access phase");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error flag without ready");
	unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
		else $error("unmapped address not refused");
	ro_write_a: assert property (PREADY && PWRITE && ro_reg |-> PSLVERR)
		else $error("write to read-only register not refused");
	read_ok_a: assert property (PREADY && !PWRITE && mapped |-> !PSLVERR)
		else $error("mapped read refused");
	err_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
		else $error("refused read returned data");
	slot_one_a: assert property (chg1 |-> gap1_q >= 8'h45)
		else $error("output one changed inside a slot");
	slot_two_a: assert property (chg2 |-> gap2_q >= 8'h45)
		else $error("output two changed inside a slot");
endmodule : lfp_fan_ctrl_properties

bind lfp_fan_ctrl lfp_fan_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (
	.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TEMP_REMOTE_ONE(TEMP_REMOTE_ONE), .TEMP_REMOTE_TWO(TEMP_REMOTE_TWO),
	.TEMP_DIE(TEMP_DIE), .TEMP_ZONE_FOUR(TEMP_ZONE_FOUR),
	.FAN_DRIVE_OUTPUT_ONE(FAN_DRIVE_OUTPUT_ONE),
	.FAN_DRIVE_OUTPUT_TWO(FAN_DRIVE_OUTPUT_TWO));

// >>> verif/lfp_fan_stage.sv
// fan power stage model: measures period and on-time of one pwm input
`timescale 1ns/1ps
module lfp_fan_stage (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pwm,
	output int        per_q,
	output int        high_q,
	output int        n_q
);
	logic prev_q;
	int   cnt_q;
	int   hcnt_q;
	// the first period after reset is partial; users skip a few rises
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			cnt_q  <= 0;
			hcnt_q <= 0;
			n_q    <= 0;
		end else begin
			prev_q <= pwm;
			cnt_q  <= cnt_q + 1;
			hcnt_q <= hcnt_q + int'(pwm);
			if (pwm && !prev_q) begin
				per_q  <= cnt_q;
				high_q <= hcnt_q;
				n_q    <= n_q + 1;
				cnt_q  <= 1;
				hcnt_q <= 1;
			end
		end
	end
endmodule : lfp_fan_stage

// >>> verif/tb_top.sv
// self-checking bench of the fan controller: bus, steps and pwm timing
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fan1;
	logic        fan2;
	logic [8:0]  t1 = 9'h000;
	logic [8:0]  t3 = 9'h018;
	logic [31:0] q;
	logic        e;
	int          per;
	int          high;
	int          np;
	int          per2;
	int          high2;
	int          np2;
	int          err_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #20 clk = ~clk;
	lfp_fan_ctrl DUT (.CLOCK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TEMP_REMOTE_ONE(t1), .TEMP_REMOTE_TWO(9'h016), .TEMP_DIE(t3),
		.TEMP_ZONE_FOUR(9'h000), .FAN_DRIVE_OUTPUT_ONE(fan1),
		.FAN_DRIVE_OUTPUT_TWO(fan2));
	lfp_fan_stage u_stage (.clk(clk), .rst_n(rst_n), .pwm(fan1),
		.per_q(per), .high_q(high), .n_q(np));
	lfp_fan_stage u_stage2 (.clk(clk), .rst_n(rst_n), .pwm(fan2),
		.per_q(per2), .high_q(high2), .n_q(np2));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk_word(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask : chk_word
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk_word(nm, x & m, q & m);
	endtask : rd
	function automatic logic [4:0] lo(input int l);
		return (l <= 9) ? 5'(7 + l) : 5'(16 + 4 * (l - 9));
	endfunction : lo
	task automatic t_regs();
		rd("ctrl", lfp_pkg::OFS_CTRL, '1, 32'h3);
		rd("bind", lfp_pkg::OFS_BIND, '1, 32'hc3);
		rd("hyst", lfp_pkg::OFS_HYST, '1, 32'h44);
		rd("min", lfp_pkg::OFS_MIN, '1, 32'h44);
		rd("div", lfp_pkg::OFS_DIV, '1, 32'h46);
		rd("table", lfp_pkg::OFS_TBL12_H, '1, 32'h0);
		rd("temp", lfp_pkg::OFS_TEMP, '1, 32'h000c0b00);
		apb(1'b0, 8'h30, 32'h0);
		chk_word("unmapped_data", 32'h0, q);
		chk_word("unmapped_err", 32'h1, {31'h0, e});
		apb(1'b1, lfp_pkg::OFS_STAT, '1);
		chk_word("ro_write", 32'h1, {31'h0, e});
	endtask : t_regs
	task automatic t_steps();
		int         tv[6] = '{22, 23, 26, 25, 23, 20};
		int         lv[6] = '{1, 3, 12, 12, 3, 0};
		logic [4:0] o1;
		apb(1'b1, lfp_pkg::OFS_BASE, 32'h1e0a140a);
		apb(1'b1, lfp_pkg::OFS_TBL12_L, 32'h00003021);
		apb(1'b1, lfp_pkg::OFS_TBL34_L, 32'h4);
		apb(1'b1, lfp_pkg::OFS_HYST, 32'h12);
		for (int i = 0; i < 6; i++) begin
			t1 <= 9'(tv[i]);
			repeat (3) @(posedge clk);
			// idle zones fall back to min duty rescaled to 28ths
			o1 = (i == 5) ? 5'((4 * 7) >> 2) : lo(lv[i]);
			rd("stat", lfp_pkg::OFS_STAT, (i == 5) ? 32'h3fff0f00
				: 32'h3fff0f0f, {2'b0, lo(12), o1, 3'b101, i == 5,
				12'h0c0, 4'(lv[i])});
		end
		apb(1'b1, lfp_pkg::OFS_CTRL, 32'h1);
		t1 <= 9'h017;
		repeat (3) @(posedge clk);
		rd("whole_units", lfp_pkg::OFS_STAT, 32'hf, 32'h1);
	endtask : t_steps
	task automatic t_pwm(input logic [31:0] c, input int den, input int n,
		input int den2, input int n2);
		int n0;
		int m0;
		// die zone cooled to its base so output two runs at minimum duty
		t3 <= 9'h014;
		// a divider below the floor must still run at the floor rate
		apb(1'b1, lfp_pkg::OFS_DIV, 32'h10);
		apb(1'b1, lfp_pkg::OFS_CTRL, c);
		n0 = np;
		m0 = np2;
		wait (np >= n0 + 3 && np2 >= m0 + 3);
		@(posedge clk);
		chk_word("period", 32'(den * 70), 32'(per));
		chk_word("on_time", 32'(n * 70), 32'(high));
		chk_word("period_two", 32'(den2 * 70), 32'(per2));
		chk_word("on_time_two", 32'(n2 * 70), 32'(high2));
	endtask : t_pwm
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_steps();
		t_pwm(32'h7, 16, 4 + 3, 28, 7);
		t_pwm(32'hb, 28, lo(3), 16, 4);
		end_of_test();
	end
endmodule : tb_top
